// *** verilog/flda_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef FLDA_MAP_SVH
`define FLDA_MAP_SVH

`define FLDA_OFS_CTRL      8'h00
`define FLDA_OFS_TXD       8'h04
`define FLDA_OFS_RXD       8'h08
`define FLDA_OFS_STAT      8'h0c

`define FLDA_CTRL_START    0
`define FLDA_CTRL_BCAST    1
`define FLDA_CTRL_CODE_LO  4
`define FLDA_CTRL_CODE_HI  7
`define FLDA_CTRL_DIR      7
`define FLDA_CTRL_LEN_LO   16
`define FLDA_CTRL_LEN_HI   23

`define FLDA_STAT_BUSY     0
`define FLDA_STAT_DONE     1
`define FLDA_STAT_ABORT    2
`define FLDA_STAT_TXFULL   3
`define FLDA_STAT_RXFULL   4
`define FLDA_STAT_CNT_LO   8
`define FLDA_STAT_CNT_HI   15
`define FLDA_STAT_REM_LO   16
`define FLDA_STAT_REM_HI   24

`define FLDA_CTRL_RST      32'h0000_0000
`define FLDA_LEN_256       9'h100

`define FLDA_CLK_NS        40
`define FLDA_BIT_NS        1600
`define FLDA_BIT_CYC       (`FLDA_BIT_NS / `FLDA_CLK_NS)
`define FLDA_FRAME_MAX     32

`endif

// *** verilog/flda_pkg.sv ***
// Types shared by the frame field controller
package flda_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_LEN  = 6'b00_0010,
        ST_LACK = 6'b00_0100,
        ST_LOAD = 6'b00_1000,
        ST_DAT  = 6'b01_0000,
        ST_DACK = 6'b10_0000
    } flda_state_t;
endpackage

// *** verilog/flda_bit_if.sv ***
// Bit slot request and answer between field sequencer and bit engine
`timescale 1ns/10ps
`default_nettype none
interface flda_bit_if;
    logic go;
    logic drv;
    logic dout;
    logic done;
    logic din;
    modport ctl (output go, output drv, output dout, input done, input din);
    modport eng (input go, input drv, input dout, output done, output din);
endinterface
`default_nettype wire

// *** verilog/flda_bitio.sv ***
// Bit slot engine: one bus bit per request, master sync every slot
`timescale 1ns/10ps
`default_nettype none
`include "flda_map.svh"
module flda_bitio #(
    parameter int BIT_CYC = `FLDA_BIT_CYC
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    flda_bit_if.eng     bit_io,
    input  wire logic   bus_dat_i,
    output logic        bus_dat_o,
    output logic        bus_dat_oe,
    output logic        bus_sync_o
);
    logic [15:0] div_r;
    logic        run_r;
    logic        done_r;
    logic        din_r;

    assign bit_io.done = done_r;
    assign bit_io.din  = din_r;

    // Sync on every slot, also when the far unit supplies the bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r      <= 1'b0;
            div_r      <= 16'h0000;
            done_r     <= 1'b0;
            din_r      <= 1'b1;
            bus_dat_o  <= 1'b1;
            bus_dat_oe <= 1'b0;
            bus_sync_o <= 1'b0;
        end else begin
            done_r     <= 1'b0;
            bus_sync_o <= 1'b0;
            if (!run_r) begin
                if (bit_io.go) begin
                    run_r      <= 1'b1;
                    div_r      <= 16'h0000;
                    bus_sync_o <= 1'b1;
                    bus_dat_o  <= bit_io.dout;
                    bus_dat_oe <= bit_io.drv;
                end
            end else if (div_r == 16'(BIT_CYC - 1)) begin
                // Sample at slot end, after the far unit has settled
                run_r      <= 1'b0;
                done_r     <= 1'b1;
                din_r      <= bus_dat_i;
                bus_dat_oe <= 1'b0;
                bus_dat_o  <= 1'b1;
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/flda_top.sv ***
// Master-side length/data field controller with APB registers
//
// Functional notes
// - Length: 8 bits MSB first, parity, ack
// - Length 01h..ffh is count, 00h is 256
// - Later frames carry remaining byte count
// - Control bit 7 picks who drives data
// - Slave acks even length parity, not broadcast
// - Master acks received length only on even parity
// - Data: 8 bits MSB first, parity, ack
// - Broadcast: acks ignored, no retries
// - Reading master syncs every read bit
// - Even parity bit: one when ones odd
// - Ack slot: zero ack, one nak
// - Data nak on parity or full, then resend
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "flda_map.svh"
module flda_top
    import flda_pkg::*;
#(
    parameter int BIT_CYC   = `FLDA_BIT_CYC,
    parameter int FRAME_MAX = `FLDA_FRAME_MAX
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_dat_i,
    output logic             bus_dat_o,
    output logic             bus_dat_oe,
    output logic             bus_sync_o
);
    import flda_pkg::*;

    flda_bit_if bit_if ();

    flda_state_t state_r;
    logic [8:0]  sh_r;
    logic [3:0]  bcnt_r;
    logic        pend_r;
    logic        go_r;
    logic        drv_r;
    logic        dout_r;
    logic        dir_r;
    logic        bc_r;
    logic [8:0]  rem_r;
    logic [7:0]  cnt_r;
    logic [7:0]  txb_r;
    logic        ok_r;
    logic        tx_take_r;
    logic        rx_put_r;
    logic [7:0]  rx_hold_r;
    logic        done_set_r;
    logic        abort_set_r;

    logic [31:0] ctrl_r;
    logic        start_r;
    logic [7:0]  tx_byte_r;
    logic        tx_full_r;
    logic [7:0]  rx_byte_r;
    logic        rx_full_r;
    logic        done_r;
    logic        abort_r;

    logic        wr_acc;
    logic        rd_acc;
    logic        setup;
    logic [8:0]  sh_in;
    logic        acked;
    logic        last;
    logic [7:0]  len_code;

    assign bit_if.go   = go_r;
    assign bit_if.drv  = drv_r;
    assign bit_if.dout = dout_r;

    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pready & pwrite;
    assign rd_acc   = psel & penable & pready & ~pwrite;
    assign sh_in    = {sh_r[7:0], bit_if.din};
    assign len_code = ctrl_r[`FLDA_CTRL_LEN_HI:`FLDA_CTRL_LEN_LO];
    // Zero answer is an ack; broadcast never waits on it
    assign acked    = dir_r ? (bc_r | ~bit_if.din) : ok_r;
    // Frame ends on the last wanted byte or the FRAME_MAX data-field limit
    assign last = (acked && rem_r == 9'h001)
               || (cnt_r == 8'(FRAME_MAX - 1));

    flda_bitio #(
        .BIT_CYC    (BIT_CYC)
    ) u_bitio (
        .pclk       (pclk),
        .presetn    (presetn),
        .bit_io     (bit_if),
        .bus_dat_i  (bus_dat_i),
        .bus_dat_o  (bus_dat_o),
        .bus_dat_oe (bus_dat_oe),
        .bus_sync_o (bus_sync_o)
    );

    // APB slave, zero wait: answer in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= 1'b0;
            if (setup) begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    `FLDA_OFS_CTRL: prdata <= ctrl_r;
                    `FLDA_OFS_TXD:  prdata <= {24'h00_0000, tx_byte_r};
                    `FLDA_OFS_RXD:  prdata <= {24'h00_0000, rx_byte_r};
                    `FLDA_OFS_STAT: begin
                        // Busy covers the flag landing, so an idle read
                        // never shows a finished frame without its outcome
                        prdata[`FLDA_STAT_BUSY]   <= (state_r != ST_IDLE)
                            | done_set_r | abort_set_r;
                        prdata[`FLDA_STAT_DONE]   <= done_r;
                        prdata[`FLDA_STAT_ABORT]  <= abort_r;
                        prdata[`FLDA_STAT_TXFULL] <= tx_full_r;
                        prdata[`FLDA_STAT_RXFULL] <= rx_full_r;
                        prdata[`FLDA_STAT_CNT_HI:`FLDA_STAT_CNT_LO] <= cnt_r;
                        prdata[`FLDA_STAT_REM_HI:`FLDA_STAT_REM_LO] <= rem_r;
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Control register and start strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= `FLDA_CTRL_RST;
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (wr_acc && paddr == `FLDA_OFS_CTRL) begin
                ctrl_r  <= pwdata;
                ctrl_r[`FLDA_CTRL_START] <= 1'b0;
                start_r <= pwdata[`FLDA_CTRL_START];
            end
        end
    end

    // Transmit holding byte; a write while full is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte_r <= 8'h00;
            tx_full_r <= 1'b0;
        end else if (wr_acc && paddr == `FLDA_OFS_TXD && !tx_full_r) begin
            tx_byte_r <= pwdata[7:0];
            tx_full_r <= 1'b1;
        end else if (tx_take_r) begin
            tx_full_r <= 1'b0;
        end
    end

    // Receive buffer; new byte wins over a reading clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_byte_r <= 8'h00;
            rx_full_r <= 1'b0;
        end else if (rx_put_r) begin
            rx_byte_r <= rx_hold_r;
            rx_full_r <= 1'b1;
        end else if (rd_acc && paddr == `FLDA_OFS_RXD) begin
            rx_full_r <= 1'b0;
        end
    end

    // Sticky outcome flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r  <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            if (done_set_r)
                done_r <= 1'b1;
            else if (wr_acc && paddr == `FLDA_OFS_STAT
                     && pwdata[`FLDA_STAT_DONE])
                done_r <= 1'b0;
            if (abort_set_r)
                abort_r <= 1'b1;
            else if (wr_acc && paddr == `FLDA_OFS_STAT
                     && pwdata[`FLDA_STAT_ABORT])
                abort_r <= 1'b0;
        end
    end

    // Field sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= ST_IDLE;
            sh_r        <= 9'h000;
            bcnt_r      <= 4'h0;
            pend_r      <= 1'b0;
            go_r        <= 1'b0;
            drv_r       <= 1'b0;
            dout_r      <= 1'b1;
            dir_r       <= 1'b0;
            bc_r        <= 1'b0;
            rem_r       <= 9'h000;
            cnt_r       <= 8'h00;
            txb_r       <= 8'h00;
            ok_r        <= 1'b0;
            tx_take_r   <= 1'b0;
            rx_put_r    <= 1'b0;
            rx_hold_r   <= 8'h00;
            done_set_r  <= 1'b0;
            abort_set_r <= 1'b0;
        end else begin
            go_r        <= 1'b0;
            tx_take_r   <= 1'b0;
            rx_put_r    <= 1'b0;
            done_set_r  <= 1'b0;
            abort_set_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (start_r) begin
                        // Software reloads the remaining count per frame
                        rem_r  <= (len_code == 8'h00) ? `FLDA_LEN_256
                                                      : {1'b0, len_code};
                        cnt_r  <= 8'h00;
                        bcnt_r <= 4'h0;
                        dir_r  <= ctrl_r[`FLDA_CTRL_DIR];
                        bc_r   <= ~ctrl_r[`FLDA_CTRL_BCAST] ? 1'b0 : 1'b1;
                        sh_r   <= {len_code, ^len_code};
                        state_r <= ST_LEN;
                    end
                end
                ST_LEN, ST_DAT: begin
                    // Nine slots, MSB first then parity; slave drives on reads
                    if (!pend_r) begin
                        go_r   <= 1'b1;
                        pend_r <= 1'b1;
                        drv_r  <= dir_r;
                        dout_r <= sh_r[8];
                    end else if (bit_if.done) begin
                        pend_r <= 1'b0;
                        sh_r   <= sh_in;
                        bcnt_r <= bcnt_r + 4'h1;
                        if (bcnt_r == 4'h8) begin
                            bcnt_r <= 4'h0;
                            if (state_r == ST_LEN) begin
                                if (!dir_r && ^sh_in) begin
                                    // Odd length parity: no ack, give up
                                    abort_set_r <= 1'b1;
                                    state_r     <= ST_IDLE;
                                end else begin
                                    state_r <= ST_LACK;
                                end
                            end else begin
                                rx_hold_r <= sh_in[8:1];
                                ok_r      <= dir_r | (~^sh_in
                                             & ~(rx_full_r | rx_put_r));
                                state_r   <= ST_DACK;
                            end
                        end
                    end
                end
                ST_LACK: begin
                    // On reads this unit answers the length with a zero
                    if (!pend_r) begin
                        go_r   <= 1'b1;
                        pend_r <= 1'b1;
                        drv_r  <= ~dir_r;
                        dout_r <= 1'b0;
                    end else if (bit_if.done) begin
                        pend_r <= 1'b0;
                        if (dir_r && !bc_r && bit_if.din) begin
                            abort_set_r <= 1'b1;
                            state_r     <= ST_IDLE;
                        end else begin
                            sh_r    <= 9'h000;
                            state_r <= dir_r ? ST_LOAD : ST_DAT;
                        end
                    end
                end
                ST_LOAD: begin
                    // Take-pulse guard stops a consumed byte going twice
                    if (tx_full_r && !tx_take_r) begin
                        txb_r   <= tx_byte_r;
                        sh_r    <= {tx_byte_r, ^tx_byte_r};
                        state_r <= ST_DAT;
                    end
                end
                ST_DACK: begin
                    if (!pend_r) begin
                        go_r   <= 1'b1;
                        pend_r <= 1'b1;
                        drv_r  <= ~dir_r & ok_r;
                        dout_r <= 1'b0;
                    end else if (bit_if.done) begin
                        pend_r <= 1'b0;
                        cnt_r  <= cnt_r + 8'h01;
                        if (acked) begin
                            rem_r     <= rem_r - 9'h001;
                            tx_take_r <= dir_r;
                            rx_put_r  <= ~dir_r;
                        end
                        if (last) begin
                            done_set_r <= 1'b1;
                            state_r    <= ST_IDLE;
                        end else if (dir_r && acked) begin
                            state_r <= ST_LOAD;
                        end else if (dir_r) begin
                            // Nak: same byte again
                            sh_r    <= {txb_r, ^txb_r};
                            state_r <= ST_DAT;
                        end else begin
                            sh_r    <= 9'h000;
                            state_r <= ST_DAT;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** sim/flda_slave_model.sv ***
// Behavioural slave unit answering the controller on the wired bus
`timescale 1ns/10ps
`default_nettype none
module flda_slave_model #(
    parameter int BIT_CYC = 4
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sync,
    input  wire logic line,
    output logic      drv,
    output logic      val
);
    // Scenario knobs, set by the bench between frames
    logic       dir = 1'b1;  // Set: master writes to this unit; clear: it reads
    logic       bcast = 1'b0;
    logic       len_nak = 1'b0;
    logic       rd_bad = 1'b0;
    logic [7:0] rd_len = 8'h02;
    int         nak_n = 0;
    int         bad_n = 0;
    int         par_err = 0;
    logic [7:0] got[$];
    logic [7:0] sh, len_seen, rd_b;
    logic       ok, dead, m_ack, d, v, lf;
    int         slot, cyc, f, idx;

    task automatic sample();
        if (f < 8) sh = {sh[6:0], line};
        else if (f == 8 && dir) begin
            if (^sh != line) par_err++;
            if (lf) len_seen = sh;
            ok = !bcast && ^sh == line;
            if (lf ? len_nak : nak_n > 0) ok = 1'b0;
            if (lf && !ok && !bcast) dead = 1'b1;
            if (!lf && !bcast && nak_n > 0) nak_n--;
            if (!lf && (ok || bcast)) got.push_back(sh);
        end else if (f == 9 && !dir) begin
            // Length nak from the master ends the frame for us too
            if (lf) begin
                m_ack = line;
                dead = line;
            end else if (!line) begin
                got.push_back(rd_b);
                idx++;
            end else if (bad_n > 0) bad_n--;
        end
    endtask

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot = -1;
            cyc = 0;
            idx = 0;
            ok = 1'b0;
            dead = 1'b0;
            drv <= 1'b0;
            val <= 1'b1;
        end else if (sync) begin
            slot = slot + 1;
            cyc = 0;
            lf = slot < 10;
            f = lf ? slot : (slot - 10) % 10;
            rd_b = 8'ha0 + 8'(idx);
            d = (!dir && f < 9) || (dir && f == 9 && ok);
            v = 1'b0;
            if (!dir && f < 8) v = lf ? rd_len[7-f] : rd_b[7-f];
            if (!dir && f == 8) v = lf ? ^rd_len ^ rd_bad : ^rd_b ^ (bad_n > 0);
            drv <= d && !dead;
            val <= v;
        end else begin
            cyc = cyc + 1;
            // Let go once the slot is over so stale bits never linger
            if (cyc == BIT_CYC) drv <= 1'b0;
            // Frame state is cleared by the bench at each start, so a
            // long wait for transmit data never looks like a new frame
            if (cyc == BIT_CYC / 2) sample();
        end
    end
endmodule
`default_nettype wire

// *** sim/flda_top_asserts.sv ***
// Port-level protocol checks for the frame field controller
`timescale 1ns/10ps
`default_nettype none
`include "flda_map.svh"
module flda_top_asserts #(
    parameter int BIT_CYC   = 40,
    parameter int FRAME_MAX = 32
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bus_dat_i,
    input wire logic        bus_dat_o,
    input wire logic        bus_dat_oe,
    input wire logic        bus_sync_o
);
    logic [7:0]  cnt_r;
    logic [15:0] slot_r;
    logic        dir_r;
    logic        start_w;
    assign start_w = psel && penable && pready && pwrite
                     && paddr == `FLDA_OFS_CTRL && pwdata[0];
    // Cycles since last slot start; zero until the first slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_r <= 8'h00;
        else if (bus_sync_o) cnt_r <= 8'h01;
        else if (cnt_r != 8'h00 && cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) slot_r <= 16'h0000;
        else if (start_w) slot_r <= 16'h0000;
        else if (bus_sync_o) slot_r <= slot_r + 16'h0001;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dir_r <= 1'b0;
        else if (start_w) dir_r <= pwdata[`FLDA_CTRL_DIR];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready late after setup");
    chk_err_map: assert property (pready |-> pslverr == !(paddr inside
        {`FLDA_OFS_CTRL, `FLDA_OFS_TXD, `FLDA_OFS_RXD, `FLDA_OFS_STAT}))
        else $error("pslverr wrong for address");
    chk_sync_pulse: assert property (bus_sync_o |=> !bus_sync_o)
        else $error("sync pulse longer than one cycle");
    chk_sync_gap: assert property (bus_sync_o && cnt_r != 8'h00
        |-> cnt_r >= BIT_CYC) else $error("slot shorter than bit time");
    chk_slot_stable: assert property (cnt_r != 8'h00 &&
        cnt_r < BIT_CYC && !bus_sync_o |-> $stable(bus_dat_o)
        && $stable(bus_dat_oe)) else $error("bit changed inside slot");
    chk_oe_rise: assert property ($rose(bus_dat_oe) |-> bus_sync_o)
        else $error("drive began off slot start");
    chk_write_len: assert property (start_w && pwdata[7] |-> ##4
        bus_sync_o && bus_dat_oe && bus_dat_o == $past(pwdata[23], 4))
        else $error("write frame length msb wrong");
    chk_read_len: assert property (start_w && !pwdata[7] |-> ##4
        bus_sync_o && !bus_dat_oe) else $error("read frame drove length");
    chk_wr_ack_free: assert property (bus_sync_o && dir_r &&
        slot_r % 16'd10 == 16'd9 |-> !bus_dat_oe)
        else $error("master drove ack slot on write");
    chk_rd_ack_low: assert property (!dir_r && bus_dat_oe
        |-> !bus_dat_o) else $error("reading master drove a one");
    chk_frame_limit: assert property (bus_sync_o
        |-> slot_r < 10 + 10 * FRAME_MAX) else $error("frame too long");
endmodule
bind flda_top flda_top_asserts #(
    .BIT_CYC(BIT_CYC), .FRAME_MAX(FRAME_MAX)
) flda_top_asserts_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_dat_i(bus_dat_i), .bus_dat_o(bus_dat_o),
    .bus_dat_oe(bus_dat_oe), .bus_sync_o(bus_sync_o)
);
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench: APB driver, wired bus and frame scenarios
`timescale 1ns/10ps
`default_nettype none
`include "flda_map.svh"
`define M flda_slave_model_inst
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, dat_o, dat_oe, sync_o, drv, val;
    logic        line;
    int          n_mismatch = 0;
    int          cmp_count = 0;

    // Wired line: zero dominates, a released line is pulled to one
    assign line = (dat_oe ? dat_o : 1'b1) & (drv ? val : 1'b1);
    always #20 pclk = ~pclk;
    flda_top #(.BIT_CYC(4), .FRAME_MAX(4)) flda_top_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_dat_i(line), .bus_dat_o(dat_o), .bus_dat_oe(dat_oe),
        .bus_sync_o(sync_o));
    flda_slave_model #(.BIT_CYC(4)) flda_slave_model_inst (
        .pclk(pclk), .presetn(presetn), .sync(sync_o), .line(line),
        .drv(drv), .val(val));

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 100);
        if (t >= 100) n_mismatch++;
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Polls status; a bit that never settles counts as a mismatch
    task automatic wait_bit(input int b, input logic v);
        int t;
        t = 0;
        do begin
            apb(1'b0, `FLDA_OFS_STAT, 32'h0);
            t++;
        end while (rd[b] !== v && t < 1000);
        if (t >= 1000) n_mismatch++;
    endtask
    task automatic end_frame(input logic ab, input int rem);
        wait_bit(`FLDA_STAT_BUSY, 1'b0);
        `CHK("done", !ab, rd[`FLDA_STAT_DONE])
        `CHK("abort", ab, rd[`FLDA_STAT_ABORT])
        if (!ab) `CHK("remaining", 9'(rem), rd[24:16])
        apb(1'b1, `FLDA_OFS_STAT, 32'h6);
    endtask
    task automatic start(input logic [3:0] c, input logic [7:0] l,
                         input logic bc);
        // Far unit starts each frame fresh, no ack seen yet
        `M.slot = -1;
        `M.idx = 0;
        `M.dead = 1'b0;
        `M.m_ack = 1'b1;
        // Only defined codes are sent, and nothing is ever locked
        apb(1'b1, `FLDA_OFS_CTRL,
            {8'h00, l, 8'h00, c, 2'b00, bc, 1'b1});
    endtask
    task automatic t_regs();
        apb(1'b0, `FLDA_OFS_CTRL, 32'h0);
        `CHK("ctrl reset", `FLDA_CTRL_RST, rd)
        apb(1'b1, 8'h10, 32'h1);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b0, `FLDA_OFS_STAT, 32'h0);
        `CHK("stat reset", 5'h00, rd[4:0])
        $display("test regs done");
    endtask
    task automatic t_write(input logic [7:0] l, input int n,
                           input logic bc, input int nak, input int rem);
        `M.dir = 1'b1;
        `M.bcast = bc;
        `M.nak_n = nak;
        `M.got.delete();
        apb(1'b1, `FLDA_OFS_TXD, 32'h5a);
        start(4'hf, l, bc);
        for (int k = 1; k < n; k++) begin
            wait_bit(`FLDA_STAT_TXFULL, 1'b0);
            apb(1'b1, `FLDA_OFS_TXD, 32'h5a + k);
        end
        end_frame(1'b0, rem);
        `CHK("length seen", l, `M.len_seen)
        `CHK("parity errors", 0, `M.par_err)
        `CHK("bytes taken", n, `M.got.size())
        foreach (`M.got[i]) `CHK("byte", 8'h5a + 8'(i), `M.got[i])
        $display("test write len %0h bcast %0d nak %0d done", l, bc, nak);
    endtask
    task automatic t_read(input int bad, input logic drain, input int rem);
        `M.dir = 1'b0;
        `M.bad_n = bad;
        `M.got.delete();
        start(4'h7, 8'h02, 1'b0);
        for (int k = 0; k < 2 && drain; k++) begin
            wait_bit(`FLDA_STAT_RXFULL, 1'b1);
            apb(1'b0, `FLDA_OFS_RXD, 32'h0);
            `CHK("read byte", 8'ha0 + 8'(k), rd[7:0])
        end
        end_frame(1'b0, rem);
        `CHK("bytes acked", drain ? 2 : 1, `M.got.size())
        apb(1'b0, `FLDA_OFS_RXD, 32'h0);
        if (!drain) `CHK("held byte", 8'ha0, rd[7:0])
        $display("test read drain %0d done", drain);
    endtask
    task automatic t_abort(input logic d);
        `M.dir = d;
        `M.len_nak = d;
        `M.rd_bad = !d;
        start(d ? 4'hf : 4'h7, 8'h03, 1'b0);
        end_frame(1'b1, 0);
        if (!d) `CHK("length ack", 1'b1, `M.m_ack)
        `M.len_nak = 1'b0;
        `M.rd_bad = 1'b0;
        $display("test abort dir %0d done", d);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_write(8'h02, 2, 1'b0, 0, 0);
        t_write(8'h02, 2, 1'b0, 1, 0);
        t_write(8'h02, 2, 1'b1, 0, 0);
        t_write(8'h00, 4, 1'b0, 0, 252);
        t_read(1, 1'b1, 0);
        t_read(0, 1'b0, 1);
        t_abort(1'b1);
        t_abort(1'b0);
        final_report();
    end
    // More than ten times the expected run length
    initial begin
        #2400000;
        $display("watchdog expired");
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
